// [verilog/udte_device.sv]
/*
 device end of the transaction engine: answers host tokens with data and
 handshakes, sequences endpoint 0 control stages, keeps the frame counter,
 per-endpoint stall state and resume request.
 assumes the host end keeps its own rules and that the link packet layer
 already checks pid, crc and stuffing and reports them as h_err.
*/
//
// Behaviour
// - isochronous: token and data only, no handshake; the host here still ACKs iso IN data
// - setup data packet is DATA0
// - setup answered ACK if intact, else silent
// - control data stage starts DATA1, then toggles
// - control write uses OUT, read uses IN
// - status stage runs opposite to data stage
// - status stage always uses DATA1
// - interrupt IN: NAK if empty, STALL if halted
// - interrupt OUT: ACK, NAK or STALL
// - damaged OUT or setup data gets no handshake
// - host ACKs intact interrupt IN data
// - host silent on damage; device keeps data unacknowledged
// - local fifo ports serve endpoints 1 to 15 only
// - setup data to endpoint 0 is eight bytes
// - eleven-bit frame counter readable locally
// - local per-endpoint stall set, clear, report
// - local request drives resume on the link
// - payload limits 8 intr, 64 bulk, 256 iso; iso OUT length is not checked against its limit
`timescale 1ns/1ps
module udte_device
	import udte_pkg::*;
#(
	parameter int N = UDTE_EP_NUM
) (
	// clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_rstn,
	// link
	udte_link_if.device        link,
	// local control
	input  wire logic          i_enable,
	input  wire logic [N-1:0]  i_stall_set,
	input  wire logic [N-1:0]  i_stall_clr,
	input  wire logic          i_resume_req,
	input  wire logic [2*N-1:0] i_ep_class,
	// local endpoint fifo status (endpoints 1..N-1)
	input  wire logic [N-1:0]  i_tx_ready,
	input  wire logic [8:0]    i_tx_len,
	input  wire logic [N-1:0]  i_rx_room,
	// local status and events
	output logic [10:0]        o_frame,
	output logic [N-1:0]       o_stall,
	output logic               o_enabled,
	output logic               o_rx_done,
	output logic               o_tx_done,
	output logic [3:0]         o_done_ep,
	output logic               o_setup_done,
	output logic [7:0]         o_setup_type
);
	if (N < 2 || N > 16) begin : g_bad_n
		$error("endpoint count out of range");
	end

	typedef struct packed {
		logic         enabled;
		logic [10:0]  frame;
		udte_cstage_t cstage;
		logic         cread;
		logic         pend_in;
		logic [3:0]   pend_ep;
		logic         pend_out;
		udte_pid_t    out_tok;
		logic [3:0]   tok_ep;
		logic         d_valid;
		udte_pid_t    d_pid;
		logic [8:0]   d_len;
		logic         resume;
		logic         rx_done;
		logic         tx_done;
		logic [3:0]   done_ep;
		logic         setup_done;
		logic [7:0]   setup_type;
	} udte_dev_st_t;

	udte_dev_st_t st;
	udte_dev_st_t next_st;
	logic [N-1:0] toggle;
	logic [N-1:0] stall_int;
	logic         tog_flip;
	logic         tog_load;
	logic         tog_val;
	logic [3:0]   tog_ep;
	logic [N-1:0] stall_set_all;

	// toggle and stall storage
	udte_toggle_bank #(.N(N)) u_bank (
		.i_clock    (i_clock),
		.i_rstn     (i_rstn),
		.i_tog_flip (tog_flip),
		.i_tog_load (tog_load),
		.i_tog_val  (tog_val),
		.i_tog_ep   (tog_ep),
		.i_stall_set(stall_set_all),
		.i_stall_clr(i_stall_clr),
		.o_toggle   (toggle),
		.o_stall    (stall_int)
	);

	assign stall_set_all = i_stall_set;

	// class of an endpoint from the local map; endpoint 0 is always control
	function automatic udte_ep_t ep_class(input logic [3:0] ep);
		udte_ep_t c;
		c = udte_ep_t'(i_ep_class[2*ep +: 2]);
		if (ep == 4'h0)
			c = UDTE_EP_CTRL;
		return c;
	endfunction

	// payload limit per class
	function automatic logic [8:0] ep_limit(input udte_ep_t c);
		logic [8:0] l;
		unique case (c)
			UDTE_EP_INTR: l = 9'(UDTE_MAX_INTR);
			UDTE_EP_BULK: l = 9'(UDTE_MAX_BULK);
			UDTE_EP_ISO:  l = 9'(UDTE_MAX_ISO);
			UDTE_EP_CTRL: l = 9'(UDTE_MAX_CTRL);
		endcase
		return l;
	endfunction

	// transaction decode and answer
	always_comb begin
		udte_ep_t   cls;
		logic [8:0] lim;
		cls = ep_class(link.h_ep);
		lim = ep_limit(cls);
		next_st            = st;
		next_st.enabled    = i_enable;
		next_st.d_valid    = 1'b0;
		next_st.d_pid      = UDTE_PID_NONE;
		next_st.d_len      = '0;
		next_st.resume     = i_resume_req && st.enabled;
		next_st.rx_done    = 1'b0;
		next_st.tx_done    = 1'b0;
		next_st.setup_done = 1'b0;
		tog_flip = 1'b0;
		tog_load = 1'b0;
		tog_val  = 1'b0;
		tog_ep   = st.tok_ep;
		if (!st.enabled) begin
			next_st.cstage   = UDTE_CS_IDLE;
			next_st.pend_out = 1'b0;
			next_st.pend_in  = 1'b0;
		end else if (link.h_valid) begin
			unique case (link.h_pid)
				UDTE_PID_SOF: begin
					next_st.frame = link.h_frame;
				end
				UDTE_PID_SETUP, UDTE_PID_OUT: begin
					next_st.out_tok  = link.h_pid;
					next_st.tok_ep   = link.h_ep;
					next_st.pend_out = 1'b1;
					next_st.pend_in  = 1'b0;
				end
				UDTE_PID_IN: begin
					next_st.pend_out = 1'b0;
					next_st.pend_in  = 1'b0;
					next_st.tok_ep   = link.h_ep;
					next_st.d_valid  = 1'b1;
					if (link.h_ep == 4'h0) begin
						// status after write, or read data stage
						if (st.cstage == UDTE_CS_IDLE ||
							(st.cstage == UDTE_CS_DATA && !st.cread) ||
							(st.cstage == UDTE_CS_STATUS && st.cread)) begin
							next_st.d_pid = UDTE_PID_STALL;
						end else if (stall_int[0]) begin
							next_st.d_pid = UDTE_PID_STALL;
						end else if (st.cstage == UDTE_CS_STATUS) begin
							next_st.d_pid   = UDTE_PID_DATA1;
							next_st.pend_in = 1'b1;
						end else begin
							next_st.d_pid   = toggle[0] ? UDTE_PID_DATA1 : UDTE_PID_DATA0;
							next_st.d_len   = '0;
							next_st.pend_in = 1'b1;
						end
					end else if (stall_int[link.h_ep] && cls != UDTE_EP_ISO) begin
						next_st.d_pid = UDTE_PID_STALL;
					end else if (!i_tx_ready[link.h_ep]) begin
						// iso sends an empty packet rather than a handshake
						next_st.d_pid = (cls == UDTE_EP_ISO) ? UDTE_PID_DATA0 : UDTE_PID_NAK;
					end else begin
						next_st.d_pid   = (cls == UDTE_EP_ISO || !toggle[link.h_ep]) ?
							UDTE_PID_DATA0 : UDTE_PID_DATA1;
						next_st.d_len   = (i_tx_len > lim) ? lim : i_tx_len;
						next_st.pend_in = (cls != UDTE_EP_ISO);
						if (cls == UDTE_EP_ISO) begin
							next_st.tx_done = 1'b1;
							next_st.done_ep = link.h_ep;
						end
					end
				end
				UDTE_PID_DATA0, UDTE_PID_DATA1: begin
					next_st.pend_out = 1'b0;
					tog_ep = st.tok_ep;
					if (st.pend_out && st.out_tok == UDTE_PID_SETUP) begin
						// bad, wrong-length or non-DATA0 setup: no handshake
						if (!link.h_err && link.h_pid == UDTE_PID_DATA0 && st.tok_ep == 4'h0 &&
							link.h_len == 9'(UDTE_SETUP_LEN)) begin
							next_st.d_valid    = 1'b1;
							next_st.d_pid      = UDTE_PID_ACK;
							next_st.cread      = |(link.h_byte0 & UDTE_DIR_IN_BIT);
							next_st.cstage     = UDTE_CS_DATA;
							next_st.setup_done = 1'b1;
							next_st.setup_type = link.h_byte0;
							tog_load = 1'b1;
							tog_val  = 1'b1;
						end
					end else if (st.pend_out) begin
						cls = ep_class(st.tok_ep);
						lim = ep_limit(cls);
						if (link.h_err) begin
							next_st.d_valid = 1'b0;
						end else if (cls == UDTE_EP_ISO) begin
							next_st.rx_done = 1'b1;
							next_st.done_ep = st.tok_ep;
						end else begin
							next_st.d_valid = 1'b1;
							if (st.tok_ep == 4'h0) begin
								if (st.cstage == UDTE_CS_IDLE ||
									(st.cstage == UDTE_CS_DATA && st.cread)) begin
									// host turned round: status out after read
									if (st.cstage == UDTE_CS_DATA &&
										link.h_pid == UDTE_PID_DATA1) begin
										next_st.d_pid  = UDTE_PID_ACK;
										next_st.cstage = UDTE_CS_IDLE;
									end else begin
										next_st.d_pid = UDTE_PID_STALL;
									end
								end else if (stall_int[0]) begin
									next_st.d_pid = UDTE_PID_STALL;
								end else begin
									next_st.d_pid = UDTE_PID_ACK;
									if (link.h_pid == (toggle[0] ? UDTE_PID_DATA1 : UDTE_PID_DATA0))
										tog_flip = 1'b1;
									next_st.cstage = UDTE_CS_STATUS;
								end
							end else if (stall_int[st.tok_ep]) begin
								next_st.d_pid = UDTE_PID_STALL;
							end else if (!i_rx_room[st.tok_ep] || link.h_len > lim) begin
								next_st.d_pid = UDTE_PID_NAK;
							end else begin
								next_st.d_pid = UDTE_PID_ACK;
								if (link.h_pid == (toggle[st.tok_ep] ? UDTE_PID_DATA1 : UDTE_PID_DATA0)) begin
									tog_flip        = 1'b1;
									next_st.rx_done = (st.tok_ep != 4'h0);
									next_st.done_ep = st.tok_ep;
								end
							end
						end
					end
				end
				UDTE_PID_ACK: begin
					// only an ACK retires pending IN data; silence keeps it
					if (st.pend_in) begin
						next_st.pend_in = 1'b0;
						tog_flip = 1'b1;
						if (st.tok_ep == 4'h0) begin
							if (st.cstage == UDTE_CS_STATUS)
								next_st.cstage = UDTE_CS_IDLE;
							else
								next_st.cstage = UDTE_CS_DATA;
						end else begin
							next_st.tx_done = 1'b1;
							next_st.done_ep = st.tok_ep;
						end
					end
				end
				default: begin
					next_st.pend_out = 1'b0;
				end
			endcase
		end
		// an in to endpoint 0 during a write data stage moves the stage to status
		if (st.cstage == UDTE_CS_DATA && !st.cread && st.enabled && link.h_valid &&
			link.h_pid == UDTE_PID_IN && link.h_ep == 4'h0)
			next_st.cstage = UDTE_CS_STATUS;
	end

	// state register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			st <= '0;
		else
			st <= next_st;
	end

	// outputs straight from flip-flops
	assign link.d_valid   = st.d_valid;
	assign link.d_pid     = st.d_pid;
	assign link.d_len     = st.d_len;
	assign link.d_resume  = st.resume;
	assign o_frame        = st.frame;
	assign o_stall        = stall_int;
	assign o_enabled      = st.enabled;
	assign o_rx_done      = st.rx_done;
	assign o_tx_done      = st.tx_done;
	assign o_done_ep      = st.done_ep;
	assign o_setup_done   = st.setup_done;
	assign o_setup_type   = st.setup_type;
endmodule

// [verilog/udte_pkg.sv]
/*
 the package shared by both ends of the transaction link: packet identifiers,
 handshake codes, endpoint classes, payload limits and state encodings.
 assumes nothing of its surroundings beyond a systemverilog compiler.
*/
package udte_pkg;

	// packet identifier codes on the link
	typedef enum logic [3:0] {
		UDTE_PID_NONE  = 4'h0,
		UDTE_PID_OUT   = 4'h1,
		UDTE_PID_IN    = 4'h9,
		UDTE_PID_SOF   = 4'h5,
		UDTE_PID_SETUP = 4'hd,
		UDTE_PID_DATA0 = 4'h3,
		UDTE_PID_DATA1 = 4'hb,
		UDTE_PID_ACK   = 4'h2,
		UDTE_PID_NAK   = 4'ha,
		UDTE_PID_STALL = 4'he
	} udte_pid_t;

	// endpoint transfer classes
	typedef enum logic [1:0] {
		UDTE_EP_CTRL = 2'h0,
		UDTE_EP_ISO  = 2'h1,
		UDTE_EP_BULK = 2'h2,
		UDTE_EP_INTR = 2'h3
	} udte_ep_t;

	// control transfer stage of endpoint 0
	typedef enum logic [1:0] {
		UDTE_CS_IDLE   = 2'h0,
		UDTE_CS_DATA   = 2'h1,
		UDTE_CS_STATUS = 2'h2
	} udte_cstage_t;

	// field widths and limits
	localparam int UDTE_EP_NUM      = 16;
	localparam int UDTE_FRAME_W     = 11;
	localparam int UDTE_LEN_W       = 9;
	localparam int UDTE_SETUP_LEN   = 8;
	localparam int UDTE_MAX_INTR    = 8;
	localparam int UDTE_MAX_BULK    = 64;
	localparam int UDTE_MAX_ISO     = 256;
	localparam int UDTE_MAX_CTRL    = 64;
	localparam int UDTE_TURN_CYCLES = 16;
	localparam logic [7:0] UDTE_DIR_IN_BIT = 8'h80;

endpackage

// [verilog/udte_link_if.sv]
/*
 the packet-level link between the device engine and the host engine.
 assumes both ends run on the same clock; one packet word per strobe.
*/
`timescale 1ns/1ps
interface udte_link_if;
	import udte_pkg::*;

	// host to device
	logic            h_valid;
	udte_pid_t       h_pid;
	logic [3:0]      h_ep;
	logic [10:0]     h_frame;
	logic [8:0]      h_len;
	logic            h_err;
	logic [7:0]      h_byte0;
	// device to host
	logic            d_valid;
	udte_pid_t       d_pid;
	logic [8:0]      d_len;
	logic            d_resume;

	modport device (
		input  h_valid, h_pid, h_ep, h_frame, h_len, h_err, h_byte0,
		output d_valid, d_pid, d_len, d_resume
	);
	modport host (
		output h_valid, h_pid, h_ep, h_frame, h_len, h_err, h_byte0,
		input  d_valid, d_pid, d_len, d_resume
	);
endinterface

// [verilog/udte_toggle_bank.sv]
/*
 per-endpoint data toggle and stall bits, one flip-flop pair each.
 assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module udte_toggle_bank
	import udte_pkg::*;
#(
	parameter int N = UDTE_EP_NUM
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rstn,
	// toggle control
	input  wire logic         i_tog_flip,
	input  wire logic         i_tog_load,
	input  wire logic         i_tog_val,
	input  wire logic [3:0]   i_tog_ep,
	// stall control
	input  wire logic [N-1:0] i_stall_set,
	input  wire logic [N-1:0] i_stall_clr,
	// state out
	output logic [N-1:0]      o_toggle,
	output logic [N-1:0]      o_stall
);
	if (N < 2 || N > 16) begin : g_bad_n
		$error("endpoint count out of range");
	end

	// toggles advance on accepted data; stall set wins over clear
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_toggle <= '0;
			o_stall  <= '0;
		end else begin
			if (i_tog_load)
				o_toggle[i_tog_ep] <= i_tog_val;
			else if (i_tog_flip)
				o_toggle[i_tog_ep] <= ~o_toggle[i_tog_ep];
			o_stall <= (o_stall & ~i_stall_clr) | i_stall_set;
		end
	end
endmodule

// [verilog/udte_host.sv]
/*
 host end of the transaction engine: issues tokens and data on user
 request and answers device data with ACK or silence.
 assumes the device end keeps its own rules; one transaction at a time.
*/
`timescale 1ns/1ps
module udte_host
	import udte_pkg::*;
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// link
	udte_link_if.host        link,
	// user request
	input  wire logic        i_req,
	input  wire logic [3:0]  i_pid,
	input  wire logic [3:0]  i_ep,
	input  wire logic [10:0] i_frame,
	input  wire logic [8:0]  i_len,
	input  wire logic        i_err,
	input  wire logic [7:0]  i_byte0,
	input  wire logic        i_in_bad,
	// user answer
	output logic             o_ans_valid,
	output logic [3:0]       o_ans_pid,
	output logic [8:0]       o_ans_len,
	output logic             o_resume
);
	typedef struct packed {
		logic       h_valid;
		udte_pid_t  h_pid;
		logic [3:0] h_ep;
		logic [10:0] h_frame;
		logic [8:0] h_len;
		logic       h_err;
		logic [7:0] h_byte0;
		logic       ans_valid;
		logic [3:0] ans_pid;
		logic [8:0] ans_len;
		logic       resume;
	} udte_host_st_t;

	udte_host_st_t st;
	udte_host_st_t next_st;

	// drive requests, acknowledge intact device data
	always_comb begin
		next_st           = st;
		next_st.h_valid   = 1'b0;
		next_st.ans_valid = 1'b0;
		next_st.resume    = link.d_resume;
		if (link.d_valid) begin
			next_st.ans_valid = 1'b1;
			next_st.ans_pid   = link.d_pid;
			next_st.ans_len   = link.d_len;
			if ((link.d_pid == UDTE_PID_DATA0 || link.d_pid == UDTE_PID_DATA1) &&
				!i_in_bad && st.h_pid == UDTE_PID_IN) begin
				next_st.h_valid = 1'b1;
				next_st.h_pid   = UDTE_PID_ACK;
				next_st.h_err   = 1'b0;
			end
		end else if (i_req) begin
			next_st.h_valid = 1'b1;
			next_st.h_pid   = udte_pid_t'(i_pid);
			next_st.h_ep    = i_ep;
			next_st.h_frame = i_frame;
			next_st.h_len   = i_len;
			next_st.h_err   = i_err;
			next_st.h_byte0 = i_byte0;
		end
	end

	// state register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign link.h_valid = st.h_valid;
	assign link.h_pid   = st.h_pid;
	assign link.h_ep    = st.h_ep;
	assign link.h_frame = st.h_frame;
	assign link.h_len   = st.h_len;
	assign link.h_err   = st.h_err;
	assign link.h_byte0 = st.h_byte0;
	assign o_ans_valid  = st.ans_valid;
	assign o_ans_pid    = st.ans_pid;
	assign o_ans_len    = st.ans_len;
	assign o_resume     = st.resume;
endmodule

// [bench/udte_monitor.sv]
/*
 checker for the packet link between the device and host engines.
 assumes it sits beside the link interface, fed with its signals, one clock.
*/
`timescale 1ns/1ps
module udte_monitor
	import udte_pkg::*;
#(
	parameter logic [3:0] ISO_EP = 4'h1
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// host to device
	input  wire logic        h_valid,
	input  wire udte_pid_t   h_pid,
	input  wire logic [3:0]  h_ep,
	input  wire logic [10:0] h_frame,
	input  wire logic [8:0]  h_len,
	input  wire logic        h_err,
	input  wire logic [7:0]  h_byte0,
	// device to host
	input  wire logic        d_valid,
	input  wire udte_pid_t   d_pid,
	input  wire logic [8:0]  d_len,
	input  wire logic        d_resume
);
	udte_pid_t  tok_pid;   // last token seen
	logic [3:0] tok_ep;    // endpoint of that token
	logic       live;      // device has answered since reset
	logic       ep0_fresh; // setup seen, no ep0 data from device yet
	logic       h_data;
	logic       d_data;

	// data packets on either side
	assign h_data = h_valid && (h_pid == UDTE_PID_DATA0 || h_pid == UDTE_PID_DATA1);
	assign d_data = d_valid && (d_pid == UDTE_PID_DATA0 || d_pid == UDTE_PID_DATA1);

	// token and control stage tracking
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			tok_pid   <= UDTE_PID_NONE;
			tok_ep    <= 4'h0;
			live      <= 1'b0;
			ep0_fresh <= 1'b0;
		end else begin
			if (d_valid) begin
				live <= 1'b1;
			end
			if (h_valid && h_pid inside {UDTE_PID_OUT, UDTE_PID_IN, UDTE_PID_SETUP}) begin
				tok_pid <= h_pid;
				tok_ep  <= h_ep;
			end
			if (h_valid && h_pid == UDTE_PID_SETUP && h_ep == 4'h0) begin
				ep0_fresh <= 1'b1;
			end else if (d_data && tok_pid == UDTE_PID_IN && tok_ep == 4'h0) begin
				ep0_fresh <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	a_answer_after_packet: assert property (d_valid |-> $past(h_valid))
		else $error("device packet without a host packet the cycle before");
	a_iso_no_handshake: assert property (h_data && tok_ep == ISO_EP |=> !d_valid)
		else $error("handshake sent for isochronous data");
	a_iso_in_data: assert property (d_valid && tok_pid == UDTE_PID_IN && tok_ep == ISO_EP |-> d_data)
		else $error("isochronous in answered without data");
	a_setup_acked: assert property (live && h_data && !h_err && h_pid == UDTE_PID_DATA0
		&& h_len == 9'h8 && tok_pid == UDTE_PID_SETUP && tok_ep == 4'h0
		|=> d_valid && d_pid == UDTE_PID_ACK) else $error("intact setup not acknowledged");
	a_setup_data1_silent: assert property (h_valid && h_pid == UDTE_PID_DATA1
		&& tok_pid == UDTE_PID_SETUP |=> !d_valid) else $error("setup with data1 answered");
	a_setup_len_exact: assert property (h_data && tok_pid == UDTE_PID_SETUP
		&& h_len != 9'h8 |=> !d_valid) else $error("setup of wrong length answered");
	a_damaged_silent: assert property (h_data && h_err |=> !d_valid)
		else $error("damaged data answered");
	a_ctrl_first_data1: assert property (d_data && tok_pid == UDTE_PID_IN
		&& tok_ep == 4'h0 && ep0_fresh |-> d_pid == UDTE_PID_DATA1)
		else $error("first device data after setup not data1");
	a_in_reply_kind: assert property (d_valid && tok_pid == UDTE_PID_IN |-> d_pid inside
		{UDTE_PID_DATA0, UDTE_PID_DATA1, UDTE_PID_NAK, UDTE_PID_STALL})
		else $error("bad packet kind answering an in token");
	a_out_reply_kind: assert property (d_valid && tok_pid != UDTE_PID_IN |-> d_pid inside
		{UDTE_PID_ACK, UDTE_PID_NAK, UDTE_PID_STALL}) else $error("bad handshake to host data");
	a_host_ack_only: assert property (d_data && tok_pid == UDTE_PID_IN
		|=> !h_valid || h_pid == UDTE_PID_ACK) else $error("host answered device data with non-ack");
	a_len_limit: assert property (d_valid |-> d_len <= (d_data ? 9'h100 : 9'h0))
		else $error("device packet longer than allowed");

	// main scenarios reached
	c_setup_ack: cover property (h_data && tok_pid == UDTE_PID_SETUP ##1 d_pid == UDTE_PID_ACK);
	c_in_stall: cover property (d_valid && d_pid == UDTE_PID_STALL && tok_pid == UDTE_PID_IN);
	c_iso_in: cover property (d_data && tok_ep == ISO_EP);
	c_host_ack: cover property (d_data ##1 h_valid && h_pid == UDTE_PID_ACK);
endmodule

// [bench/udte_tb.sv]
/*
 self-checking bench: device and host engines joined by the link interface.
 assumes a 10 mhz clock; ep1 iso, ep2 interrupt, ep3 bulk, others control.
*/
`timescale 1ns/1ps
module usb_device_transaction_engine_tb import udte_pkg::*;;
	logic        i_clock = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_enable = 1'b0;
	logic        i_resume_req = 1'b0;
	logic        i_req = 1'b0;
	logic        i_err = 1'b0;
	logic        i_in_bad = 1'b0;
	logic [15:0] i_stall_set = 16'h0, i_stall_clr = 16'h0, i_tx_ready = 16'h0, i_rx_room = 16'h0;
	logic [31:0] i_ep_class = 32'h000000b4;
	logic [8:0]  i_tx_len = 9'h0, i_len = 9'h0, o_ans_len;
	logic [3:0]  i_pid = 4'h0, i_ep = 4'h0, o_done_ep, o_ans_pid;
	logic [10:0] i_frame = 11'h0, o_frame;
	logic [7:0]  i_byte0 = 8'h0, o_setup_type;
	logic [15:0] o_stall;
	logic        o_enabled, o_rx_done, o_tx_done, o_setup_done, o_ans_valid, o_resume;
	int          err_count = 0;
	int          compares = 0;
	int          k, n_rx = 0, n_tx = 0, n_su = 0;

	// clock
	always #50 i_clock = ~i_clock;

	// done events tallied with their endpoint or setup type
	always @(negedge i_clock) begin
		if (o_rx_done === 1'b1) n_rx += 16 + o_done_ep;
		if (o_tx_done === 1'b1) n_tx += 16 + o_done_ep;
		if (o_setup_done === 1'b1) n_su += 16 + o_setup_type;
	end

	// both ends across one link, checker beside it
	udte_link_if udte_link_if_inst ();
	udte_device udte_device_inst (.i_clock(i_clock), .i_rstn(i_rstn),
		.link(udte_link_if_inst.device), .i_enable(i_enable), .i_stall_set(i_stall_set),
		.i_stall_clr(i_stall_clr), .i_resume_req(i_resume_req), .i_ep_class(i_ep_class),
		.i_tx_ready(i_tx_ready), .i_tx_len(i_tx_len), .i_rx_room(i_rx_room), .o_frame(o_frame),
		.o_stall(o_stall), .o_enabled(o_enabled), .o_rx_done(o_rx_done), .o_tx_done(o_tx_done),
		.o_done_ep(o_done_ep), .o_setup_done(o_setup_done), .o_setup_type(o_setup_type));
	udte_host udte_host_inst (.i_clock(i_clock), .i_rstn(i_rstn), .link(udte_link_if_inst.host),
		.i_req(i_req), .i_pid(i_pid), .i_ep(i_ep), .i_frame(i_frame), .i_len(i_len),
		.i_err(i_err), .i_byte0(i_byte0), .i_in_bad(i_in_bad), .o_ans_valid(o_ans_valid),
		.o_ans_pid(o_ans_pid), .o_ans_len(o_ans_len), .o_resume(o_resume));
	udte_monitor #(.ISO_EP(4'h1)) udte_monitor_inst (.i_clock(i_clock), .i_rstn(i_rstn),
		.h_valid(udte_link_if_inst.h_valid), .h_pid(udte_link_if_inst.h_pid),
		.h_ep(udte_link_if_inst.h_ep), .h_frame(udte_link_if_inst.h_frame),
		.h_len(udte_link_if_inst.h_len), .h_err(udte_link_if_inst.h_err),
		.h_byte0(udte_link_if_inst.h_byte0), .d_valid(udte_link_if_inst.d_valid),
		.d_pid(udte_link_if_inst.d_pid), .d_len(udte_link_if_inst.d_len),
		.d_resume(udte_link_if_inst.d_resume));

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one host request for one cycle
	task automatic put(input udte_pid_t p, input logic [3:0] e, input logic [8:0] n, input logic b);
		i_req = 1'b1;
		i_pid = p;
		i_ep = e;
		i_len = n;
		i_err = b;
		@(negedge i_clock);
	endtask

	// one transaction; exp none means silence, exp_len 1ff means length not judged
	task automatic xp(input udte_pid_t tok, input logic [3:0] e, input udte_pid_t dp,
		input logic [8:0] n, input logic b, input udte_pid_t exp, input logic [8:0] exp_len);
		logic       got = 1'b0;
		logic [3:0] pid = 4'h0;
		logic [8:0] len = 9'h0;
		put(tok, e, 9'h0, 1'b0);
		if (tok != UDTE_PID_IN && tok != UDTE_PID_SOF) begin
			put(dp, e, n, b);
		end
		i_req = 1'b0;
		for (int c = 0; c < 8; c++) begin
			if (o_ans_valid === 1'b1 && !got) begin
				got = 1'b1;
				pid = o_ans_pid;
				len = o_ans_len;
			end
			@(negedge i_clock);
		end
		chk(16'(got), 16'(exp != UDTE_PID_NONE));
		if (got) begin
			chk(16'(pid), 16'(exp));
		end
		if (got && exp_len != 9'h1ff) begin
			chk(16'(len), 16'(exp_len));
		end
	endtask

	// reset held for four cycles
	task automatic reset_dut();
		i_rstn = 1'b0;
		repeat (4) @(negedge i_clock);
		i_rstn = 1'b1;
		repeat (2) @(negedge i_clock);
	endtask

	// traffic ignored until enabled
	task automatic sc_disabled();
		chk(16'(o_enabled), 16'h0);
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA0, 9'h8, 1'b0, UDTE_PID_NONE, 9'h0);
		i_enable = 1'b1;
		for (k = 0; k < 4 && o_enabled !== 1'b1; k++) @(negedge i_clock);
		chk(16'(o_enabled), 16'h1);
		if (k == 4) stop_test();
	endtask

	// interrupt and bulk handshakes, toggles, payload limits, stall
	task automatic sc_interrupt();
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_NAK, 9'h1ff);
		i_tx_ready = 16'hffff;
		i_tx_len = 9'h8;
		i_in_bad = 1'b1;
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA0, 9'h8);
		i_in_bad = 1'b0;
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA0, 9'h8);
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA1, 9'h8);
		i_rx_room = 16'hffff;
		xp(UDTE_PID_OUT, 4'h2, UDTE_PID_DATA0, 9'h8, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h2, UDTE_PID_DATA1, 9'h9, 1'b0, UDTE_PID_NAK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h3, UDTE_PID_DATA0, 9'h41, 1'b0, UDTE_PID_NAK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h3, UDTE_PID_DATA0, 9'h40, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h2, UDTE_PID_DATA1, 9'h8, 1'b1, UDTE_PID_NONE, 9'h0);
		i_rx_room = 16'h0;
		xp(UDTE_PID_OUT, 4'h2, UDTE_PID_DATA1, 9'h8, 1'b0, UDTE_PID_NAK, 9'h1ff);
		i_stall_set = 16'h0004;
		@(negedge i_clock);
		i_stall_set = 16'h0;
		@(negedge i_clock);
		chk(o_stall, 16'h0004);
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_STALL, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h2, UDTE_PID_DATA1, 9'h8, 1'b0, UDTE_PID_STALL, 9'h1ff);
		i_stall_clr = 16'h0004;
		@(negedge i_clock);
		i_stall_clr = 16'h0;
		@(negedge i_clock);
		chk(o_stall, 16'h0);
	endtask

	// isochronous: data only, never a handshake
	task automatic sc_iso();
		i_tx_ready = 16'h0;
		xp(UDTE_PID_IN, 4'h1, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA0, 9'h0);
		i_tx_ready = 16'hffff;
		i_tx_len = 9'hc8;
		xp(UDTE_PID_IN, 4'h1, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA0, 9'hc8);
		xp(UDTE_PID_OUT, 4'h1, UDTE_PID_DATA1, 9'h20, 1'b0, UDTE_PID_NONE, 9'h0);
	endtask

	// control write then control read on endpoint 0
	task automatic sc_control();
		i_rx_room = 16'hffff;
		i_byte0 = 8'h00;
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA0, 9'h8, 1'b1, UDTE_PID_NONE, 9'h0);
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA1, 9'h8, 1'b0, UDTE_PID_NONE, 9'h0);
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA0, 9'h7, 1'b0, UDTE_PID_NONE, 9'h0);
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA0, 9'h8, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h0, UDTE_PID_DATA1, 9'h8, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h0, UDTE_PID_DATA0, 9'h8, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_IN, 4'h0, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA1, 9'h0);
		i_byte0 = 8'h80;
		xp(UDTE_PID_SETUP, 4'h0, UDTE_PID_DATA0, 9'h8, 1'b0, UDTE_PID_ACK, 9'h1ff);
		xp(UDTE_PID_IN, 4'h0, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_DATA1, 9'h1ff);
		xp(UDTE_PID_OUT, 4'h0, UDTE_PID_DATA1, 9'h0, 1'b0, UDTE_PID_ACK, 9'h1ff);
		chk(16'(n_rx), 16'h0036);
		chk(16'(n_tx), 16'h0035);
		chk(16'(n_su), 16'h00a0);
	endtask

	// frame number, resume, then disable and reset
	task automatic sc_frame_resume();
		i_frame = 11'h7ff;
		xp(UDTE_PID_SOF, 4'h0, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_NONE, 9'h0);
		for (k = 0; k < 8 && o_frame !== 11'h7ff; k++) @(negedge i_clock);
		chk(16'(o_frame), 16'h07ff);
		if (k == 8) stop_test();
		i_resume_req = 1'b1;
		for (k = 0; k < 8 && o_resume !== 1'b1; k++) @(negedge i_clock);
		chk(16'(o_resume), 16'h1);
		if (k == 8) stop_test();
		i_resume_req = 1'b0;
		i_enable = 1'b0;
		repeat (3) @(negedge i_clock);
		xp(UDTE_PID_IN, 4'h2, UDTE_PID_NONE, 9'h0, 1'b0, UDTE_PID_NONE, 9'h0);
		i_enable = 1'b1;
		repeat (2) @(negedge i_clock);
		i_rstn = 1'b0;
		@(negedge i_clock);
		chk(16'(o_enabled), 16'h0);
		reset_dut();
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge i_clock);
		err_count++;
		stop_test();
	end

	// main sequence
	initial begin
		reset_dut();
		sc_disabled();
		sc_interrupt();
		sc_iso();
		sc_control();
		sc_frame_resume();
		stop_test();
	end
endmodule
